// [src/mpr_pkg.sv]
// How it works
// - Every modem register answers at its own data-memory address, so loads and stores reach it like plain memory.
// - Writing 0 to command bit 7 at 0x2200 powers the radio down and holds the modem logic in reset.
// - While off the modem moves no packets, and software must turn it on before asking for any transfer.
// - Once the modem is off, hardware sets command bit 7 back to 1 by itself.
// - Writing 0 to command bit 6 moves the modem to the on state, ready to send or receive.
// - While on, the modem powers its transmitter and receiver up and down by itself.
// - When the modem enters the on state, hardware sets command bit 6 back to 1.
// - The modem-ready event fires when the radio has settled after an on request.
// - Reading the pending register or the index register clears every pending modem event.
// - Each modem event source can be disabled on its own through the enable register.
package mpr_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;

	// Registers with behaviour of their own
	localparam logic [15:0] ADDR_PHY_COMMAND_0 = 16'h2200;
	localparam logic [15:0] ADDR_PHY_STATE_0 = 16'h2270;
	localparam logic [15:0] ADDR_PHY_STATE_1 = 16'h2271;
	localparam logic [15:0] ADDR_GAIN_STATE_0 = 16'h2272;
	localparam logic [15:0] ADDR_GAIN_STATE_1 = 16'h2273;
	localparam logic [15:0] ADDR_GAIN_STATE_2 = 16'h2274;
	localparam logic [15:0] ADDR_GAIN_STATE_3 = 16'h2275;
	localparam logic [15:0] ADDR_MODEM_IRQ_ENABLE = 16'h2277;
	localparam logic [15:0] ADDR_MODEM_IRQ_INDEX = 16'h2278;
	localparam logic [15:0] ADDR_MODEM_IRQ_PENDING = 16'h227E;

	localparam logic [7:0] RST_PHY_COMMAND_0 = 8'hFC;
	localparam logic [7:0] RST_PHY_STATE_1 = 8'hF0;
	localparam logic [7:0] RST_GAIN_STATE_0 = 8'hFF;
	localparam logic [7:0] RST_GAIN_STATE_1 = 8'hDF;
	localparam logic [7:0] RST_GAIN_STATE_2 = 8'h00;
	localparam logic [7:0] RST_GAIN_STATE_3 = 8'h00;
	localparam logic [7:0] RST_MODEM_IRQ_ENABLE = 8'hF0;

	// Command register fields
	localparam int CMD_OFF_BIT = 7;
	localparam int CMD_ON_BIT = 6;
	localparam int CMD_LOW_W = 6;

	// State register fields
	localparam int STATE_ON_BIT = 7;
	localparam int STATE_OFF_BIT = 6;

	// Event sources, lowest number has highest priority
	localparam int NUM_SRC = 4;
	localparam int SRC_RX_END = 0;
	localparam int SRC_RX_START = 1;
	localparam int SRC_TX_END = 2;
	localparam int SRC_MODEM_READY = 3;
	localparam int IDX_NONE_BIT = 2;

	// Radio settle time after an on request
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Plain storage registers; 0x220D serves both antenna switch names
	localparam int NUM_PLAIN = 34;
	localparam logic [15:0] PLAIN_ADDR [NUM_PLAIN] = '{
		16'h2201, 16'h2202, 16'h2203, 16'h2204, 16'h2205, 16'h2206, 16'h2207,
		16'h220D, 16'h2211, 16'h2212, 16'h2213, 16'h2215, 16'h2217, 16'h2223,
		16'h2248, 16'h2249, 16'h224A, 16'h224B, 16'h2260, 16'h2261, 16'h2262,
		16'h2263, 16'h226D, 16'h226E, 16'h2279, 16'h2286, 16'h2287, 16'h2288,
		16'h2289, 16'h228A, 16'h228B, 16'h22A0, 16'h22A1, 16'h22A2
	};
	localparam logic [7:0] PLAIN_RST [NUM_PLAIN] = '{
		8'hC7, 8'hE0, 8'hFF, 8'h00, 8'hFF, 8'hD0, 8'hFF,
		8'h00, 8'h02, 8'hA7, 8'h4F, 8'hF2, 8'h63, 8'h7F,
		8'hC0, 8'hB2, 8'h01, 8'hF4, 8'h40, 8'h6C, 8'hFF,
		8'h0F, 8'h00, 8'h20, 8'h90, 8'h38, 8'h20, 8'h00,
		8'h2F, 8'h14, 8'h32, 8'h18, 8'hF8, 8'h96
	};

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_WAKE,
		MODE_ON
	} mpr_mode_t;

	typedef struct packed {
		logic [15:0] addr;
		logic we;
		logic re;
		logic [7:0] wdata;
	} mpr_bus_req_t;

	typedef struct packed {
		logic [7:0] phy_state_1;
		logic [7:0] gain_state_0;
		logic [7:0] gain_state_1;
		logic [7:0] gain_state_2;
		logic [7:0] gain_state_3;
	} mpr_status_in_t;

endpackage

// [src/mpr_modem_seq.sv]
`timescale 1ns/1ps
module mpr_modem_seq
	import mpr_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic off_req,
	input wire logic on_req,
	output mpr_mode_t mode,
	output logic off_reached,
	output logic on_reached
);

	initial begin
		if (SETTLE < 1 || SETTLE > 65535) begin
			$error("SETTLE out of range");
		end
	end

	logic [15:0] settle_cnt;
	mpr_mode_t next_mode;

	// Mode decision; an off request beats an on request
	always_comb begin
		next_mode = mode;
		if (off_req) begin
			next_mode = MODE_OFF;
		end else begin
			case (mode)
				MODE_OFF: begin
					if (on_req) begin
						next_mode = MODE_WAKE;
					end
				end
				MODE_WAKE: begin
					// Radio needs time to settle before packets may flow
					if (settle_cnt == 16'(SETTLE - 1)) begin
						next_mode = MODE_ON;
					end
				end
				default: next_mode = mode;
			endcase
		end
	end

	// Mode register
	always_ff @(posedge clk) begin
		if (srst) begin
			mode <= MODE_OFF;
		end else begin
			mode <= next_mode;
		end
	end

	// Settle counter runs only while waking
	always_ff @(posedge clk) begin
		if (srst || mode != MODE_WAKE || off_req) begin
			settle_cnt <= 16'h0000;
		end else begin
			settle_cnt <= settle_cnt + 16'h0001;
		end
	end

	// Arrival pulses; a repeated request in the same mode still reports arrival
	always_ff @(posedge clk) begin
		if (srst) begin
			off_reached <= 1'b0;
			on_reached <= 1'b0;
		end else begin
			off_reached <= off_req;
			on_reached <= !off_req && ((mode == MODE_WAKE && next_mode == MODE_ON)
				|| (mode == MODE_ON && on_req));
		end
	end

endmodule

// [src/mpr_register_bank.sv]
`timescale 1ns/1ps
module mpr_register_bank
	import mpr_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire mpr_bus_req_t MEM_REQ,
	output logic [7:0] MEM_RDATA,
	output logic MEM_HIT,
	input wire mpr_status_in_t STATUS_IN,
	input wire logic RX_END_EVENT,
	input wire logic RX_START_EVENT,
	input wire logic TX_END_EVENT,
	input wire logic TX_ACTIVE,
	output logic [NUM_PLAIN*8-1:0] CTRL_REGS,
	output logic MODEM_RESET,
	output logic RADIO_POWER,
	output logic PACKET_ENABLE,
	output logic TX_POWER,
	output logic RX_POWER,
	output logic MODEM_IRQ
);

	// Addresses with behaviour of their own; the read chain tests them before the table
	function automatic logic special_hit(input logic [15:0] a);
		logic found;
		found = a == ADDR_PHY_COMMAND_0;
		found = found || (a >= ADDR_PHY_STATE_0 && a <= ADDR_GAIN_STATE_3);
		found = found || a == ADDR_MODEM_IRQ_ENABLE;
		found = found || a == ADDR_MODEM_IRQ_INDEX;
		found = found || a == ADDR_MODEM_IRQ_PENDING;
		return found;
	endfunction

	// Elaboration checks; a shadowed or doubled table entry would silently lose writes
	initial begin
		if (SETTLE < 1 || SETTLE > 65535) begin
			$error("SETTLE out of range");
		end
		// Index field carries only two bits of source number
		if (NUM_SRC < 1 || NUM_SRC > 4) begin
			$error("NUM_SRC out of range");
		end
		// Command byte is two request bits above the stored low bits
		if (CMD_LOW_W != CMD_ON_BIT || CMD_OFF_BIT != CMD_ON_BIT + 1) begin
			$error("command field layout broken");
		end
		for (int k = 0; k < NUM_PLAIN; k++) begin
			if (special_hit(PLAIN_ADDR[k])) begin
				$error("plain address shadowed");
			end
			for (int j = k + 1; j < NUM_PLAIN; j++) begin
				if (PLAIN_ADDR[j] == PLAIN_ADDR[k]) begin
					$error("plain address doubled");
				end
			end
		end
	end

	// Plain register lookup, shared by read and hit decode
	function automatic logic plain_hit(input logic [15:0] a);
		logic found;
		found = 1'b0;
		for (int k = 0; k < NUM_PLAIN; k++) begin
			if (a == PLAIN_ADDR[k]) begin
				found = 1'b1;
			end
		end
		return found;
	endfunction

	function automatic logic [7:0] plain_read(
		input logic [15:0] a,
		input logic [NUM_PLAIN*8-1:0] regs
	);
		logic [7:0] val;
		val = 8'h00;
		for (int k = 0; k < NUM_PLAIN; k++) begin
			if (a == PLAIN_ADDR[k]) begin
				val = regs[k*8 +: 8];
			end
		end
		return val;
	endfunction

	// Address decode of the special registers
	logic wr;
	logic rd;
	logic wr_cmd;
	logic wr_enable;
	logic rd_clear;

	assign wr = MEM_REQ.we;
	assign rd = MEM_REQ.re;
	assign wr_cmd = wr && MEM_REQ.addr == ADDR_PHY_COMMAND_0;
	assign wr_enable = wr && MEM_REQ.addr == ADDR_MODEM_IRQ_ENABLE;
	assign rd_clear = rd && (MEM_REQ.addr == ADDR_MODEM_IRQ_PENDING
		|| MEM_REQ.addr == ADDR_MODEM_IRQ_INDEX);

	// Plain storage, one byte per documented address
	logic [NUM_PLAIN*8-1:0] plain;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PLAIN; gi++) begin : g_plain
			always_ff @(posedge SYS_CLK) begin
				if (SRST) begin
					plain[gi*8 +: 8] <= PLAIN_RST[gi];
				end else if (wr && MEM_REQ.addr == PLAIN_ADDR[gi]) begin
					plain[gi*8 +: 8] <= MEM_REQ.wdata;
				end
			end
		end
	endgenerate

	// Values sit unchanged after loading; nothing in the block overwrites them
	assign CTRL_REGS = plain;

	// Command register: request bits plus six stored bits
	logic [CMD_LOW_W-1:0] cmd_low;
	logic off_bit;
	logic on_bit;
	logic off_req;
	logic on_req;
	logic off_reached;
	logic on_reached;
	mpr_mode_t mode;

	// A zero is a request; a one is the idle value and does nothing
	assign off_req = wr_cmd && !MEM_REQ.wdata[CMD_OFF_BIT];
	assign on_req = wr_cmd && !MEM_REQ.wdata[CMD_ON_BIT];

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			cmd_low <= RST_PHY_COMMAND_0[CMD_LOW_W-1:0];
		end else if (wr_cmd) begin
			cmd_low <= MEM_REQ.wdata[CMD_LOW_W-1:0];
		end
	end

	// Off request bit; a fresh request beats the hardware restore
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			off_bit <= RST_PHY_COMMAND_0[CMD_OFF_BIT];
		end else if (off_req) begin
			off_bit <= 1'b0;
		end else if (off_reached) begin
			off_bit <= 1'b1;
		end
	end

	// On request bit; an off request cancels a pending on request
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			on_bit <= RST_PHY_COMMAND_0[CMD_ON_BIT];
		end else if (on_req && !off_req) begin
			on_bit <= 1'b0;
		end else if (on_reached || off_req) begin
			on_bit <= 1'b1;
		end
	end

	// Modem power sequencing
	mpr_modem_seq #(
		.SETTLE(SETTLE)
	) u_seq (
		.clk(SYS_CLK),
		.srst(SRST),
		.off_req(off_req),
		.on_req(on_req),
		.mode(mode),
		.off_reached(off_reached),
		.on_reached(on_reached)
	);

	// Radio and datapath controls follow the mode
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			MODEM_RESET <= 1'b1;
			RADIO_POWER <= 1'b0;
			PACKET_ENABLE <= 1'b0;
		end else begin
			MODEM_RESET <= mode == MODE_OFF;
			RADIO_POWER <= mode != MODE_OFF;
			PACKET_ENABLE <= mode == MODE_ON;
		end
	end

	// Transmitter and receiver are swapped by hardware while on
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			TX_POWER <= 1'b0;
			RX_POWER <= 1'b0;
		end else begin
			TX_POWER <= mode == MODE_ON && TX_ACTIVE;
			RX_POWER <= mode == MODE_ON && !TX_ACTIVE;
		end
	end

	// Datapath status captured each cycle for stable reads
	mpr_status_in_t status_q;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			status_q.phy_state_1 <= RST_PHY_STATE_1;
			status_q.gain_state_0 <= RST_GAIN_STATE_0;
			status_q.gain_state_1 <= RST_GAIN_STATE_1;
			status_q.gain_state_2 <= RST_GAIN_STATE_2;
			status_q.gain_state_3 <= RST_GAIN_STATE_3;
		end else begin
			status_q <= STATUS_IN;
		end
	end

	// Event enable register; a one in a low bit disables that source
	logic [7:0] irq_enable;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			irq_enable <= RST_MODEM_IRQ_ENABLE;
		end else if (wr_enable) begin
			irq_enable <= MEM_REQ.wdata;
		end
	end

	// Event sources; datapath events only count while the modem is on
	logic [NUM_SRC-1:0] src;

	always_comb begin
		src = '0;
		src[SRC_RX_END] = RX_END_EVENT && mode == MODE_ON;
		src[SRC_RX_START] = RX_START_EVENT && mode == MODE_ON;
		src[SRC_TX_END] = TX_END_EVENT && mode == MODE_ON;
		src[SRC_MODEM_READY] = on_reached;
	end

	// Sticky pending bits; a new event in the clearing cycle survives
	logic [NUM_SRC-1:0] pend;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			pend <= '0;
		end else begin
			pend <= (pend & {NUM_SRC{!rd_clear}}) | src;
		end
	end

	// Enabled pending sources drive the index and the line out
	logic [NUM_SRC-1:0] live;
	logic [1:0] top_src;
	logic any_live;

	assign live = pend & ~irq_enable[NUM_SRC-1:0];

	always_comb begin
		top_src = 2'h0;
		any_live = 1'b0;
		for (int k = NUM_SRC - 1; k >= 0; k--) begin
			if (live[k]) begin
				top_src = k[1:0];
				any_live = 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			MODEM_IRQ <= 1'b0;
		end else begin
			MODEM_IRQ <= any_live;
		end
	end

	// Pending reads active low; index reads none-flag high when idle
	logic [7:0] pend_view;
	logic [7:0] index_view;
	logic [7:0] state_view;

	assign pend_view = {{(8 - NUM_SRC){1'b1}}, ~pend};
	assign index_view = {5'h1F, !any_live, top_src};

	always_comb begin
		state_view = 8'h00;
		state_view[STATE_ON_BIT] = mode == MODE_ON;
		state_view[STATE_OFF_BIT] = mode == MODE_OFF;
	end

	// Read decode; address chain keeps the plain table last
	logic [7:0] next_rdata;
	logic next_hit;

	always_comb begin
		next_hit = 1'b1;
		if (MEM_REQ.addr == ADDR_PHY_COMMAND_0) begin
			next_rdata = {off_bit, on_bit, cmd_low};
		end else if (MEM_REQ.addr == ADDR_PHY_STATE_0) begin
			next_rdata = state_view;
		end else if (MEM_REQ.addr == ADDR_PHY_STATE_1) begin
			next_rdata = status_q.phy_state_1;
		end else if (MEM_REQ.addr == ADDR_GAIN_STATE_0) begin
			next_rdata = status_q.gain_state_0;
		end else if (MEM_REQ.addr == ADDR_GAIN_STATE_1) begin
			next_rdata = status_q.gain_state_1;
		end else if (MEM_REQ.addr == ADDR_GAIN_STATE_2) begin
			next_rdata = status_q.gain_state_2;
		end else if (MEM_REQ.addr == ADDR_GAIN_STATE_3) begin
			next_rdata = status_q.gain_state_3;
		end else if (MEM_REQ.addr == ADDR_MODEM_IRQ_ENABLE) begin
			next_rdata = irq_enable;
		end else if (MEM_REQ.addr == ADDR_MODEM_IRQ_INDEX) begin
			next_rdata = index_view;
		end else if (MEM_REQ.addr == ADDR_MODEM_IRQ_PENDING) begin
			next_rdata = pend_view;
		end else if (plain_hit(MEM_REQ.addr)) begin
			next_rdata = plain_read(MEM_REQ.addr, plain);
		end else begin
			// Unmapped addresses read as zero and report no hit
			next_rdata = 8'h00;
			next_hit = 1'b0;
		end
	end

	// Read data one cycle after the strobe, held until the next read
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			MEM_RDATA <= 8'h00;
		end else if (rd) begin
			MEM_RDATA <= next_rdata;
		end
	end

	// Hit flag marks every decoded access for one cycle
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			MEM_HIT <= 1'b0;
		end else begin
			MEM_HIT <= (rd || wr) && next_hit;
		end
	end

endmodule

// [testbench/mpr_cpu_model.sv]
`timescale 1ns/1ps
module mpr_cpu_model
	import mpr_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic hit,
	output mpr_bus_req_t req
);
	initial req = '{addr: 16'h0000, we: 1'b0, re: 1'b0, wdata: 8'h00};

	// One load or store: strobe set at a falling edge, so one rising edge takes it
	task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q, output logic h);
		@(negedge clk);
		req <= '{addr: a, we: w, re: !w, wdata: d};
		@(negedge clk);
		q = rdata;
		h = hit;
		// Released lines show the inverse, so a stale value never looks valid
		req <= '{addr: ~a, we: 1'b0, re: 1'b0, wdata: ~d};
	endtask
endmodule

// [testbench/mpr_register_bank_monitor.sv]
`timescale 1ns/1ps
module mpr_register_bank_monitor
	import mpr_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire mpr_bus_req_t MEM_REQ,
	input wire logic [7:0] MEM_RDATA,
	input wire logic MEM_HIT,
	input wire logic RX_END_EVENT,
	input wire logic RX_START_EVENT,
	input wire logic TX_END_EVENT,
	input wire logic [NUM_PLAIN*8-1:0] CTRL_REGS,
	input wire logic MODEM_RESET,
	input wire logic RADIO_POWER,
	input wire logic PACKET_ENABLE,
	input wire logic TX_POWER,
	input wire logic RX_POWER,
	input wire logic MODEM_IRQ
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	logic cmd_wr;
	logic ev_any;
	int wake_cnt;
	assign cmd_wr = MEM_REQ.we && MEM_REQ.addr == ADDR_PHY_COMMAND_0;
	assign ev_any = RX_END_EVENT || RX_START_EVENT || TX_END_EVENT;

	// Cycles powered but not yet open for packets
	always_ff @(posedge SYS_CLK) begin
		wake_cnt <= (!SRST && RADIO_POWER && !PACKET_ENABLE) ? wake_cnt + 1 : 0;
	end

	pkt_off_a: assert property (PACKET_ENABLE |-> RADIO_POWER && !MODEM_RESET)
		else $error("packets enabled while modem off");
	pwr_split_a: assert property ((TX_POWER || RX_POWER) |-> RADIO_POWER && !(TX_POWER && RX_POWER))
		else $error("transmit and receive power out of step");
	hit_cause_a: assert property (MEM_HIT |-> $past(MEM_REQ.we) || $past(MEM_REQ.re))
		else $error("hit without an access");
	rd_unmap_a: assert property (MEM_REQ.re && MEM_REQ.addr == 16'h2208 |=> !MEM_HIT && MEM_RDATA == 8'h00)
		else $error("unmapped read answered");
	rd_data_a: assert property (MEM_REQ.re && !MEM_REQ.we && MEM_REQ.addr == 16'h2212
		|=> MEM_HIT && MEM_RDATA == $past(CTRL_REGS[79:72])) else $error("sync word read wrong");
	off_req_a: assert property (cmd_wr && !MEM_REQ.wdata[CMD_OFF_BIT]
		|=> ##1 MODEM_RESET && !RADIO_POWER) else $error("off request not obeyed");
	wake_pwr_a: assert property (cmd_wr && MEM_REQ.wdata[7:6] == 2'b10 && MODEM_RESET
		&& !$past(MEM_REQ.we) |=> ##1 RADIO_POWER) else $error("on request not obeyed");
	settle_len_a: assert property ($rose(PACKET_ENABLE) |-> wake_cnt == SETTLE)
		else $error("settle time wrong");
	irq_clear_a: assert property (MEM_REQ.re && MEM_REQ.addr == ADDR_MODEM_IRQ_PENDING && !ev_any
		|=> ##1 !MODEM_IRQ) else $error("pending read left interrupt up");
endmodule

bind mpr_register_bank mpr_register_bank_monitor #(.SETTLE(SETTLE)) i_mon (
	.SYS_CLK(SYS_CLK), .SRST(SRST), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA),
	.MEM_HIT(MEM_HIT), .RX_END_EVENT(RX_END_EVENT), .RX_START_EVENT(RX_START_EVENT),
	.TX_END_EVENT(TX_END_EVENT), .CTRL_REGS(CTRL_REGS), .MODEM_RESET(MODEM_RESET),
	.RADIO_POWER(RADIO_POWER), .PACKET_ENABLE(PACKET_ENABLE), .TX_POWER(TX_POWER),
	.RX_POWER(RX_POWER), .MODEM_IRQ(MODEM_IRQ));

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
	import mpr_pkg::*;
;
	localparam int SET = 8;
	localparam logic [15:0] CMD = ADDR_PHY_COMMAND_0;
	logic clk = 1'b0;
	logic srst = 1'b1;
	mpr_bus_req_t req;
	logic [7:0] rdata;
	logic hit;
	mpr_status_in_t status = '{8'h81, 8'h3C, 8'h5A, 8'hA5, 8'h18};
	logic [2:0] ev = 3'b000;
	logic tx_act = 1'b0;
	logic rst_o, rpow, pkt, txp, rxp, irq;
	logic [7:0] q;
	logic h;
	logic [NUM_PLAIN*8-1:0] ctrl;
	int errors = 0;
	int n_checks = 0;

	always #2 clk = ~clk;

	mpr_cpu_model i_cpu (.clk(clk), .rdata(rdata), .hit(hit), .req(req));
	mpr_register_bank #(.SETTLE(SET)) i_dut (.SYS_CLK(clk), .SRST(srst), .MEM_REQ(req),
		.MEM_RDATA(rdata), .MEM_HIT(hit), .STATUS_IN(status), .RX_END_EVENT(ev[0]),
		.RX_START_EVENT(ev[1]), .TX_END_EVENT(ev[2]), .TX_ACTIVE(tx_act), .CTRL_REGS(ctrl),
		.MODEM_RESET(rst_o), .RADIO_POWER(rpow), .PACKET_ENABLE(pkt), .TX_POWER(txp),
		.RX_POWER(rxp), .MODEM_IRQ(irq));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		i_cpu.access(a, 1'b1, d, q, h);
	endtask

	// Masked read, so undefined low bits of a control byte stay out of it
	task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] exp);
		i_cpu.access(a, 1'b0, 8'h00, q, h);
		check("read data", q & m, exp);
		check("hit", {7'h00, h}, {7'h00, a != 16'h2208});
	endtask

	task automatic pulse(input logic [2:0] e);
		@(negedge clk);
		ev = e;
		@(negedge clk);
		ev = 3'b000;
	endtask

	task automatic flags(input logic [7:0] exp);
		check("flags", {2'b00, rst_o, rpow, pkt, txp, rxp, irq}, exp);
	endtask

	task automatic give_verdict;
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#40000;
		errors++;
		give_verdict;
	end

	initial begin
		repeat (3) @(negedge clk);
		srst = 1'b0;
		// Every plain byte: reset value, own pattern, then back to the supplied value
		foreach (PLAIN_ADDR[k]) begin
			rd(PLAIN_ADDR[k], 8'hFF, PLAIN_RST[k]);
			wr(PLAIN_ADDR[k], ~PLAIN_RST[k]);
			rd(PLAIN_ADDR[k], 8'hFF, ~PLAIN_RST[k]);
			wr(PLAIN_ADDR[k], PLAIN_RST[k]);
		end
		foreach (PLAIN_RST[k]) check("control byte", ctrl[k*8 +: 8], PLAIN_RST[k]);
		rd(CMD, 8'hFF, RST_PHY_COMMAND_0);
		rd(ADDR_MODEM_IRQ_ENABLE, 8'hFF, RST_MODEM_IRQ_ENABLE);
		rd(ADDR_MODEM_IRQ_INDEX, 8'hFF, 8'hFC);
		rd(ADDR_MODEM_IRQ_PENDING, 8'hFF, 8'hFF);
		rd(ADDR_PHY_STATE_0, 8'hFF, 8'h40);
		// Status bytes follow the datapath and shrug off stores
		wr(ADDR_GAIN_STATE_0, 8'h00);
		rd(ADDR_GAIN_STATE_0, 8'hFF, status.gain_state_0);
		rd(ADDR_PHY_STATE_1, 8'hFF, status.phy_state_1);
		rd(ADDR_GAIN_STATE_1, 8'hFF, status.gain_state_1);
		rd(ADDR_GAIN_STATE_2, 8'hFF, status.gain_state_2);
		rd(ADDR_GAIN_STATE_3, 8'hFF, status.gain_state_3);
		wr(16'h2208, 8'h55);
		rd(16'h2208, 8'hFF, 8'h00);
		check("hit", {7'h00, h}, 8'h00);
		// Datapath events are dropped while off
		pulse(3'b111);
		rd(ADDR_MODEM_IRQ_PENDING, 8'hFF, 8'hFF);
		// Turn on; the request bit stays low through settling
		wr(CMD, 8'hBF);
		rd(CMD, 8'hC0, 8'h80);
		for (int i = 0; i < 40 && pkt !== 1'b1; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		flags(8'h1B);
		rd(CMD, 8'hC0, 8'hC0);
		rd(ADDR_PHY_STATE_0, 8'hC0, 8'h80);
		rd(ADDR_MODEM_IRQ_PENDING, 8'hFF, 8'hF7);
		rd(ADDR_MODEM_IRQ_PENDING, 8'hFF, 8'hFF);
		flags(8'h1A);
		// A repeated on request keeps the mode and reports ready again
		wr(CMD, 8'hBF);
		rd(CMD, 8'hC0, 8'hC0);
		rd(ADDR_MODEM_IRQ_PENDING, 8'hFF, 8'hF7);
		// Transmitter and receiver follow the datapath alone
		tx_act = 1'b1;
		repeat (2) @(negedge clk);
		flags(8'h1C);
		tx_act = 1'b0;
		repeat (2) @(negedge clk);
		flags(8'h1A);
		// Each datapath source gives its own index; the index read clears all
		for (int i = 0; i < 3; i++) begin
			pulse(3'b001 << i);
			rd(ADDR_MODEM_IRQ_INDEX, 8'hFF, {5'h1F, 1'b0, 2'(i)});
			rd(ADDR_MODEM_IRQ_PENDING, 8'hFF, 8'hFF);
		end
		pulse(3'b110);
		rd(ADDR_MODEM_IRQ_INDEX, 8'hFF, 8'hF9);
		// A disabled source stays out of index and interrupt
		wr(ADDR_MODEM_IRQ_ENABLE, 8'hF2);
		pulse(3'b010);
		repeat (2) @(negedge clk);
		flags(8'h1A);
		rd(ADDR_MODEM_IRQ_INDEX, 8'hFF, 8'hFC);
		wr(ADDR_MODEM_IRQ_ENABLE, 8'hF0);
		// Idle value written back changes nothing
		wr(CMD, 8'hFF);
		repeat (4) @(negedge clk);
		flags(8'h1A);
		// Both requests low: off wins and the bit comes back
		wr(CMD, 8'h3F);
		repeat (2) @(negedge clk);
		flags(8'h20);
		rd(CMD, 8'hC0, 8'hC0);
		rd(ADDR_PHY_STATE_0, 8'hC0, 8'h40);
		// Off during settling aborts the turn-on
		wr(CMD, 8'hBF);
		wr(CMD, 8'h7F);
		repeat (2 * SET) @(negedge clk);
		flags(8'h20);
		// Reset in mid-run while on; ready stays masked off the line
		wr(ADDR_MODEM_IRQ_ENABLE, 8'hFF);
		wr(CMD, 8'hBF);
		repeat (2 * SET) @(negedge clk);
		flags(8'h1A);
		srst = 1'b1;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		flags(8'h20);
		rd(CMD, 8'hFF, RST_PHY_COMMAND_0);
		rd(ADDR_MODEM_IRQ_ENABLE, 8'hFF, RST_MODEM_IRQ_ENABLE);
		rd(ADDR_MODEM_IRQ_PENDING, 8'hFF, 8'hFF);
		give_verdict;
	end
endmodule
